// File: shared/ptptsr_defines.svh
// Offsets, field layouts, reset values and constants of the timestamp rewriter.
// Notes on behaviour
// R1 - Two-step ingress match writes reserved header bytes.
// R2 - Write puts timestamp ns, then regenerates FCS.
// R3 - Reserved = ts - latency; Sync adds asymmetry.
// R4 - Receiver zeroes reserved bytes before integrity check.
// R5 - Two-step egress match saves; passes 15 identifier bytes.
// R6 - Software puts sequence identifier inside frame identifier.
// R7 - Save stores transmit time with identifier bytes.
// R8 - Egress FIFO = ts plus latency; Delay_req subtracts asymmetry.
// R9 - Mode A ingress subtracts at 8-byte correction field.
// R10 - Subtract: correction minus receive timestamp in ns.
// R11 - Mode A ingress subtracts ts; Sync adds asymmetry.
// R12 - Mode A egress adds timestamp to correction field.
// R13 - Unmatched frames pass unchanged; timestamp discarded.
// R14 - Rewrite overwrites bytes and replaces FCS.
// R15 - Bad incoming FCS gives inverted regenerated FCS.
// R16 - Mode A egress adds ts; Delay_req subtracts asymmetry.
// R17 - Mode B ingress writes reserved; Sync adds asymmetry.
// R18 - Mode B egress adds ts, subtracts reserved.
// R19 - Mode B egress clears reserved bytes to zero.
// R20 - System configures both ends' classifiers for Sync/Delay_req.
// R21 - Latency correction is programmable.
// R22 - Link asymmetry is programmable.
// R23 - Delay line holds bytes until rewrite values ready.
`ifndef PTPTSR_DEFINES_SVH
`define PTPTSR_DEFINES_SVH

`define PTPTSR_OFF_ETYPE_HI 16'h000c
`define PTPTSR_OFF_ETYPE_LO 16'h000d
`define PTPTSR_OFF_MSGTYPE 16'h000e
`define PTPTSR_OFF_DOMAIN 16'h0012
`define PTPTSR_OFF_COPY 16'h0015
`define PTPTSR_OFF_CF 16'h0016
`define PTPTSR_OFF_CF_END 16'h001e
`define PTPTSR_OFF_RES 16'h001e
`define PTPTSR_OFF_RES_END 16'h0022
`define PTPTSR_OFF_CALC 16'h0022
`define PTPTSR_ETHERTYPE 16'h88f7
`define PTPTSR_MSG_SYNC 4'h0
`define PTPTSR_MSG_DREQ 4'h1
`define PTPTSR_ID_BYTES 16'h000f
`define PTPTSR_CRC_INIT 32'hffffffff
`define PTPTSR_CRC_RESIDUE 32'hdebb20e3
`define PTPTSR_CRC_POLY 32'hedb88320
`define PTPTSR_E_VLD 10
`define PTPTSR_E_SOF 9
`define PTPTSR_E_EOF 8
`define PTPTSR_E_W 11

`endif

// File: shared/ptptsr_pkg.sv
// Types shared by the timestamp rewriter modules.
package ptptsr_pkg;

  typedef enum logic [1:0] {
    PTPTSR_TWO_STEP = 2'b00,
    PTPTSR_TC_A = 2'b01,
    PTPTSR_TC_B = 2'b10,
    PTPTSR_OFF = 2'b11
  } ptptsr_mode_t;

endpackage : ptptsr_pkg

// File: hw/ptptsr_crc32.sv
// One-byte step of the Ethernet CRC-32, reflected form.
`timescale 1ns/1ps
`include "ptptsr_defines.svh"
module ptptsr_crc32 (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  logic [31:0] chain [0:8];

  assign chain[0] = crc_in;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      assign chain[b+1] = (chain[b][0] ^ data[b]) ?
        ((chain[b] >> 1) ^ `PTPTSR_CRC_POLY) : (chain[b] >> 1);
    end
  endgenerate

  assign crc_out = chain[8];
endmodule : ptptsr_crc32

// File: hw/ptptsr_ts_fifo.sv
// Transmit timestamp FIFO: records of identifier and time, read by the CPU.
`timescale 1ns/1ps
module ptptsr_ts_fifo #(
  parameter int W = 152,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  output logic overflow,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_q [0:DEPTH-1];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign rd_valid = !empty;
  assign rd_data = mem_q[rd_q[AW-1:0]];
  // A record arriving while full is dropped; the pulse lets software resync.
  assign overflow = push && full;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
    end else if (push && !full) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push && !full) begin
      mem_q[wr_q[AW-1:0]] <= push_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= '0;
    end else if (rd_ready && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule : ptptsr_ts_fifo

// File: hw/ptptsr_top.sv
// Per-port PTP frame analyzer, timestamp unit and rewriter with timestamp FIFO.
`timescale 1ns/1ps
`include "ptptsr_defines.svh"
module ptptsr_top
  import ptptsr_pkg::*;
#(
  parameter int DLY = 24,
  parameter int FIFO_DEPTH = 4,
  parameter int FIFO_AW = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_enable,
  input wire ptptsr_mode_t cfg_mode,
  input wire logic cfg_egress,
  input wire logic [7:0] cfg_domain,
  input wire logic [31:0] cfg_latency_ns,
  input wire logic [31:0] cfg_asym_ns,
  input wire logic [15:0] cfg_id_offset,
  input wire logic [31:0] local_time_ns,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sof,
  input wire logic rx_eof,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_sof,
  output logic tx_eof,
  output logic frame_matched,
  output logic tsf_valid,
  input wire logic tsf_ready,
  output logic [31:0] tsf_ts,
  output logic [119:0] tsf_id,
  output logic tsf_overflow
);
  localparam int EW = `PTPTSR_E_W;

  // Input side: position, header fields and the captured timestamp.
  logic [15:0] ipos_q;
  logic [15:0] cur_pos;
  logic [15:0] etype_q;
  logic [3:0] mt_q;
  logic match_q;
  logic sync_q;
  logic [63:0] cf_in_q;
  logic [31:0] res_in_q;
  logic [119:0] id_q;
  logic [31:0] ts_raw_q;
  logic [31:0] ts_val;
  logic [63:0] cf_new_q;
  logic fcs_bad_q;
  logic [31:0] crc_i_q;
  logic [31:0] crc_i_seed;
  logic [31:0] crc_i_next;

  // Action decoded from mode, direction and frame type.
  logic act_wres;
  logic act_wcf;
  logic act_save;
  logic ts_add;
  logic ts_sub;
  logic res_sub;
  logic [31:0] res_val;
  logic [63:0] cf_calc;
  logic push;

  // Delay line and output side.
  logic [DLY*EW-1:0] dl_q;
  logic [EW-1:0] o_ent;
  logic o_vld;
  logic o_sof;
  logic o_eof;
  logic [7:0] o_data;
  logic o_fcs;
  logic [15:0] opos_q;
  logic [15:0] o_cur;
  logic o_wcf_q;
  logic o_wres_q;
  logic o_mod_q;
  logic [63:0] o_cf_q;
  logic [31:0] o_res_q;
  logic [31:0] crc_o_q;
  logic [31:0] crc_o_seed;
  logic [31:0] crc_o_next;
  logic fcs_act_q;
  logic [31:0] fcs_sh_q;
  logic [31:0] fcs_word;
  logic [7:0] o_byte;
  logic in_cf;
  logic in_res;

  assign cur_pos = rx_sof ? 16'h0000 : ipos_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ipos_q <= 16'h0000;
    end else if (rx_valid) begin
      ipos_q <= cur_pos + 16'h0001;
    end
  end

  // Timestamp is taken at the start of every frame and simply dropped
  // when the frame does not match. [R13]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ts_raw_q <= 32'h00000000;
    end else if (rx_valid && rx_sof) begin
      ts_raw_q <= local_time_ns;
    end
  end

  // Ingress removes the fixed measurement latency, egress adds it. [R21] [R3] [R8]
  assign ts_val = cfg_egress ? (ts_raw_q + cfg_latency_ns) : (ts_raw_q - cfg_latency_ns);

  // Analyzer: Ethernet-encapsulated PTP, Sync or Delay_req of our domain. [R20]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      etype_q <= 16'h0000;
      mt_q <= 4'h0;
      match_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (rx_valid) begin
      if (rx_sof) begin
        match_q <= 1'b0;
      end
      if (cur_pos == `PTPTSR_OFF_ETYPE_HI) begin
        etype_q[15:8] <= rx_data;
      end
      if (cur_pos == `PTPTSR_OFF_ETYPE_LO) begin
        etype_q[7:0] <= rx_data;
      end
      if (cur_pos == `PTPTSR_OFF_MSGTYPE) begin
        mt_q <= rx_data[3:0];
      end
      if (cur_pos == `PTPTSR_OFF_DOMAIN) begin
        match_q <= cfg_enable && (cfg_mode != PTPTSR_OFF) &&
                   (etype_q == `PTPTSR_ETHERTYPE) &&
                   ((mt_q == `PTPTSR_MSG_SYNC) || (mt_q == `PTPTSR_MSG_DREQ)) &&
                   (rx_data == cfg_domain);
        sync_q <= (mt_q == `PTPTSR_MSG_SYNC);
      end
    end
  end

  // Correction field and reserved bytes arrive most significant byte first.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cf_in_q <= 64'h0;
      res_in_q <= 32'h0;
    end else if (rx_valid) begin
      if (cur_pos >= `PTPTSR_OFF_CF && cur_pos < `PTPTSR_OFF_CF_END) begin
        cf_in_q <= {cf_in_q[55:0], rx_data};
      end
      if (cur_pos >= `PTPTSR_OFF_RES && cur_pos < `PTPTSR_OFF_RES_END) begin
        res_in_q <= {res_in_q[23:0], rx_data};
      end
    end
  end

  // Identifier window; software must place it over the sequence identifier. [R6] [R5]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      id_q <= 120'h0;
    end else if (rx_valid && rx_sof) begin
      id_q <= 120'h0;
    end else if (rx_valid && cur_pos >= cfg_id_offset &&
                 cur_pos < cfg_id_offset + `PTPTSR_ID_BYTES) begin
      id_q <= {id_q[111:0], rx_data};
    end
  end

  always_comb begin
    act_wres = 1'b0;
    act_wcf = 1'b0;
    act_save = 1'b0;
    ts_add = 1'b0;
    ts_sub = 1'b0;
    res_sub = 1'b0;
    res_val = ts_val;
    case (cfg_mode)
      PTPTSR_TWO_STEP: begin
        if (!cfg_egress) begin
          act_wres = 1'b1; // [R1] [R2]
          act_wcf = sync_q; // [R3]
        end else begin
          act_save = 1'b1; // [R5] [R7]
          act_wcf = !sync_q; // [R8]
        end
      end
      PTPTSR_TC_A: begin
        act_wcf = 1'b1; // [R9] [R12]
        ts_sub = !cfg_egress; // [R10] [R11]
        ts_add = cfg_egress; // [R16]
      end
      PTPTSR_TC_B: begin
        if (!cfg_egress) begin
          act_wres = 1'b1; // [R17]
          act_wcf = sync_q;
        end else begin
          act_wcf = 1'b1; // [R18]
          ts_add = 1'b1;
          res_sub = 1'b1;
          act_wres = 1'b1;
          res_val = 32'h00000000; // [R19]
        end
      end
      default: begin
        act_wres = 1'b0;
      end
    endcase
  end

  // Correction field is in 2^-16 ns units; asymmetry is signed. Ingress adds it
  // to Sync, egress subtracts it from Delay_req. [R22] [R11] [R16] [R18]
  always_comb begin
    cf_calc = cf_in_q;
    if (ts_add) begin
      cf_calc = cf_calc + {16'h0000, ts_val, 16'h0000};
    end
    if (ts_sub) begin
      cf_calc = cf_calc - {16'h0000, ts_val, 16'h0000};
    end
    if (res_sub) begin
      cf_calc = cf_calc - {16'h0000, res_in_q, 16'h0000};
    end
    if (!cfg_egress && sync_q) begin
      cf_calc = cf_calc + {{16{cfg_asym_ns[31]}}, cfg_asym_ns, 16'h0000};
    end
    if (cfg_egress && !sync_q) begin
      cf_calc = cf_calc - {{16{cfg_asym_ns[31]}}, cfg_asym_ns, 16'h0000};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cf_new_q <= 64'h0;
    end else if (rx_valid && cur_pos == `PTPTSR_OFF_CALC) begin
      cf_new_q <= cf_calc;
    end
  end

  // Incoming FCS check over the whole frame, FCS included.
  assign crc_i_seed = rx_sof ? `PTPTSR_CRC_INIT : crc_i_q;

  ptptsr_crc32 u_crc_in (
    .crc_in(crc_i_seed),
    .data(rx_data),
    .crc_out(crc_i_next)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      crc_i_q <= `PTPTSR_CRC_INIT;
      fcs_bad_q <= 1'b0;
    end else if (rx_valid) begin
      crc_i_q <= crc_i_next;
      if (rx_eof) begin
        fcs_bad_q <= (crc_i_next != `PTPTSR_CRC_RESIDUE); // [R15]
      end
    end
  end

  assign push = rx_valid && rx_eof && match_q && act_save; // [R7]
  assign frame_matched = rx_valid && rx_eof && match_q;

  ptptsr_ts_fifo #(
    .W(152),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .push(push),
    .push_data({id_q, ts_val}),
    .overflow(tsf_overflow),
    .rd_valid(tsf_valid),
    .rd_ready(tsf_ready),
    .rd_data({tsf_id, tsf_ts})
  );

  // Frame bytes wait here long enough that the new correction field,
  // which depends on reserved bytes that follow it, is ready in time. [R23]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dl_q <= '0;
    end else begin
      dl_q <= {dl_q[(DLY-1)*EW-1:0], rx_valid, rx_sof, rx_eof, rx_data};
    end
  end

  assign o_ent = dl_q[DLY*EW-1 -: EW];
  assign o_vld = o_ent[`PTPTSR_E_VLD];
  assign o_sof = o_ent[`PTPTSR_E_SOF];
  assign o_eof = o_ent[`PTPTSR_E_EOF];
  assign o_data = o_ent[7:0];
  // The last four bytes of a frame are the FCS: end of frame lies within them.
  assign o_fcs = o_vld && (o_eof || dl_q[(DLY-2)*EW+`PTPTSR_E_EOF] ||
                 dl_q[(DLY-3)*EW+`PTPTSR_E_EOF] || dl_q[(DLY-4)*EW+`PTPTSR_E_EOF]);
  assign o_cur = o_sof ? 16'h0000 : opos_q;
  assign in_cf = o_wcf_q && o_cur >= `PTPTSR_OFF_CF && o_cur < `PTPTSR_OFF_CF_END;
  assign in_res = o_wres_q && o_cur >= `PTPTSR_OFF_RES && o_cur < `PTPTSR_OFF_RES_END;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      opos_q <= 16'h0000;
    end else if (o_vld) begin
      opos_q <= o_cur + 16'h0001;
    end
  end

  // Decisions are handed over just before the first byte they touch, so the
  // input side is free for the next frame; unmatched frames are untouched. [R13]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      o_wcf_q <= 1'b0;
      o_wres_q <= 1'b0;
      o_mod_q <= 1'b0;
      o_cf_q <= 64'h0;
      o_res_q <= 32'h0;
    end else if (o_vld) begin
      if (o_sof) begin
        o_wcf_q <= 1'b0;
        o_wres_q <= 1'b0;
        o_mod_q <= 1'b0;
      end else if (o_cur == `PTPTSR_OFF_COPY) begin
        o_wcf_q <= match_q && act_wcf;
        o_wres_q <= match_q && act_wres;
        o_mod_q <= match_q && (act_wcf || act_wres);
        o_cf_q <= cf_new_q;
        o_res_q <= res_val;
      end else begin
        if (in_cf) begin
          o_cf_q <= {o_cf_q[55:0], 8'h00};
        end
        if (in_res) begin
          o_res_q <= {o_res_q[23:0], 8'h00};
        end
      end
    end
  end

  // A bad incoming FCS leaves as the inverse of the good one. [R15]
  assign fcs_word = fcs_bad_q ? crc_o_q : ~crc_o_q;

  always_comb begin
    o_byte = o_data;
    if (in_cf) begin
      o_byte = o_cf_q[63:56]; // [R10] [R12] [R14]
    end
    if (in_res) begin
      o_byte = o_res_q[31:24]; // [R2] [R19]
    end
    if (o_mod_q && o_fcs) begin
      o_byte = fcs_act_q ? fcs_sh_q[7:0] : fcs_word[7:0]; // [R14]
    end
  end

  assign crc_o_seed = o_sof ? `PTPTSR_CRC_INIT : crc_o_q;

  ptptsr_crc32 u_crc_out (
    .crc_in(crc_o_seed),
    .data(o_byte),
    .crc_out(crc_o_next)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      crc_o_q <= `PTPTSR_CRC_INIT;
      fcs_act_q <= 1'b0;
      fcs_sh_q <= 32'h0;
    end else if (o_vld) begin
      if (!o_fcs) begin
        crc_o_q <= crc_o_next;
      end
      if (o_eof) begin
        fcs_act_q <= 1'b0;
      end else if (o_fcs && !fcs_act_q) begin
        fcs_act_q <= 1'b1;
        fcs_sh_q <= {8'h00, fcs_word[31:8]};
      end else if (o_fcs) begin
        fcs_sh_q <= {8'h00, fcs_sh_q[31:8]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
    end else begin
      tx_valid <= o_vld;
      tx_data <= o_byte;
      tx_sof <= o_sof && o_vld;
      tx_eof <= o_eof && o_vld;
    end
  end
endmodule : ptptsr_top

// File: testbench/ptptsr_time_src.sv
// Local time counter model standing in for the timing engine.
`timescale 1ns/1ps
module ptptsr_time_src #(
  parameter logic [31:0] START = 32'h0000_1000
) (
  input wire logic core_clk,
  input wire logic resetn,
  output logic [31:0] local_time_ns
);
  logic [31:0] time_q;
  // The count advances by the clock period so every frame sees a fresh capture time.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      time_q <= START;
    end else begin
      time_q <= time_q + 32'h0000_000a;
    end
  end
  assign local_time_ns = time_q;
endmodule : ptptsr_time_src

// File: testbench/ptptsr_checker.sv
// Concurrent checks on the rewriter's stream and timestamp FIFO ports.
`timescale 1ns/1ps
module ptptsr_checker
  import ptptsr_pkg::*;
#(
  parameter int DLY = 24
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_enable,
  input wire ptptsr_mode_t cfg_mode,
  input wire logic cfg_egress,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_sof,
  input wire logic tx_eof,
  input wire logic frame_matched,
  input wire logic tsf_valid,
  input wire logic tsf_ready,
  input wire logic [31:0] tsf_ts,
  input wire logic [119:0] tsf_id,
  input wire logic tsf_overflow
);
  logic [7:0] up_q;
  logic warm;
  logic quiet;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // History older than the last reset release is not trusted by the delay checks.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 8'h00;
    end else if (up_q != 8'hff) begin
      up_q <= up_q + 8'h01;
    end
  end
  assign warm = int'(up_q) > DLY;
  assign quiet = !cfg_enable || cfg_mode == PTPTSR_OFF;
  a_valid_delayed: assert property (warm |-> tx_valid == $past(rx_valid, DLY + 1))
    else $error("tx_valid does not follow rx_valid");
  a_marks_delayed: assert property (warm && tx_valid |->
    tx_sof == $past(rx_sof, DLY + 1) && tx_eof == $past(rx_eof, DLY + 1))
    else $error("frame marks do not follow the input");
  a_flush_after_reset: assert property (!warm |-> !tx_valid)
    else $error("output valid before the delay line refilled");
  a_off_passes: assert property (warm && tx_valid && quiet && $past(quiet, DLY + 1) |->
    tx_data == $past(rx_data, DLY + 1))
    else $error("byte altered while classification is off");
  a_match_at_eof: assert property (frame_matched |-> rx_valid && rx_eof)
    else $error("match flag away from a last byte");
  a_no_match_disabled: assert property (!cfg_enable |-> !frame_matched)
    else $error("match while disabled");
  a_push_shows: assert property (frame_matched && cfg_egress &&
    cfg_mode == PTPTSR_TWO_STEP |=> tsf_valid)
    else $error("saved record not visible");
  a_overflow_cause: assert property (tsf_overflow |-> frame_matched && tsf_valid)
    else $error("overflow without a push into a full store");
  a_record_holds: assert property (tsf_valid && !tsf_ready |=>
    tsf_valid && $stable(tsf_ts) && $stable(tsf_id))
    else $error("head record changed without a pop");
endmodule : ptptsr_checker

bind ptptsr_top ptptsr_checker #(.DLY(DLY)) chk (
  .core_clk(core_clk), .resetn(resetn), .cfg_enable(cfg_enable), .cfg_mode(cfg_mode),
  .cfg_egress(cfg_egress), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
  .rx_eof(rx_eof), .tx_valid(tx_valid), .tx_data(tx_data), .tx_sof(tx_sof),
  .tx_eof(tx_eof), .frame_matched(frame_matched), .tsf_valid(tsf_valid),
  .tsf_ready(tsf_ready), .tsf_ts(tsf_ts), .tsf_id(tsf_id), .tsf_overflow(tsf_overflow)
);

// File: testbench/tb_ptp_frame_timestamp_rewriter.sv
// Frames through every mode and port side, FIFO readout and overflow, mid-run reset.
`timescale 1ns/1ps
`include "ptptsr_defines.svh"
module tb_ptp_frame_timestamp_rewriter
  import ptptsr_pkg::*;
();
  localparam int DEPTH = 4;
  logic core_clk, resetn, cfg_enable, cfg_egress;
  ptptsr_mode_t cfg_mode;
  logic [7:0] cfg_domain, rx_data, tx_data;
  logic [31:0] cfg_latency_ns, cfg_asym_ns, local_time_ns, tsf_ts;
  logic [15:0] cfg_id_offset;
  logic rx_valid, rx_sof, rx_eof, tx_valid, tx_sof, tx_eof, frame_matched;
  logic tsf_valid, tsf_ready, tsf_overflow;
  logic [119:0] tsf_id;
  logic [7:0] exp_q[$];
  logic [151:0] rq[$];
  int fail_count, compares, match_count, match_exp, ovf_count, ovf_exp, cyc;

  ptptsr_time_src tsrc (.core_clk(core_clk), .resetn(resetn), .local_time_ns(local_time_ns));
  ptptsr_top #(.DLY(24), .FIFO_DEPTH(DEPTH), .FIFO_AW(2)) uut (
    .core_clk(core_clk), .resetn(resetn), .cfg_enable(cfg_enable), .cfg_mode(cfg_mode),
    .cfg_egress(cfg_egress), .cfg_domain(cfg_domain), .cfg_latency_ns(cfg_latency_ns),
    .cfg_asym_ns(cfg_asym_ns), .cfg_id_offset(cfg_id_offset), .local_time_ns(local_time_ns),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_sof(tx_sof), .tx_eof(tx_eof),
    .frame_matched(frame_matched), .tsf_valid(tsf_valid), .tsf_ready(tsf_ready),
    .tsf_ts(tsf_ts), .tsf_id(tsf_id), .tsf_overflow(tsf_overflow));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // A bad flag leaves the running register uncomplemented, which is also the marked form.
  function automatic void seal(ref logic [7:0] b[64], input logic bad);
    logic [31:0] c;
    c = `PTPTSR_CRC_INIT;
    for (int i = 0; i < 60; i++) begin
      c = c ^ {24'h0, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ `PTPTSR_CRC_POLY) : (c >> 1);
    end
    c = bad ? c : ~c;
    for (int j = 0; j < 4; j++) b[60 + j] = c[8*j +: 8];
  endfunction : seal

  task automatic send(input logic [3:0] msg, input logic [7:0] dom, input logic bad);
    logic [7:0] f[64];
    logic [7:0] e[64];
    logic [63:0] cf, asx;
    logic [31:0] ts, res;
    logic [119:0] id;
    for (int i = 0; i < 60; i++) f[i] = 8'h30 + 8'(i);
    f[12] = 8'h88;
    f[13] = 8'hf7;
    f[14] = {4'h0, msg};
    f[18] = dom;
    cf = 64'h0000_0000_0123_0000;
    // Ingress frames arrive with zero reserved bytes; egress frames carry 32'h0000_2000, left there on the way in.
    res = cfg_egress ? 32'h0000_2000 : 32'h0000_0000;
    for (int i = 0; i < 8; i++) f[22 + i] = cf[63 - 8*i -: 8];
    for (int i = 0; i < 4; i++) f[30 + i] = res[31 - 8*i -: 8];
    for (int i = 0; i < 15; i++) id[119 - 8*i -: 8] = f[34 + i];
    seal(f, bad);
    e = f;
    ts = cfg_egress ? local_time_ns + cfg_latency_ns : local_time_ns - cfg_latency_ns;
    asx = {{32{cfg_asym_ns[31]}}, cfg_asym_ns} << 16;
    if (cfg_enable && cfg_mode != PTPTSR_OFF && dom == cfg_domain && msg < 4'h2) begin
      match_exp++;
      if (!cfg_egress && msg == 4'h0) cf = cf + asx;
      if (cfg_egress && msg == 4'h1) cf = cf - asx;
      case (cfg_mode)
        PTPTSR_TWO_STEP: begin
          if (!cfg_egress) res = ts;
          else if (rq.size() < DEPTH) rq.push_back({id, ts});
          else ovf_exp++;
        end
        PTPTSR_TC_A: begin
          if (cfg_egress) cf = cf + {16'h0, ts, 16'h0};
          else cf = cf - {16'h0, ts, 16'h0};
        end
        default: begin
          cf = cfg_egress ? cf + {16'h0, ts, 16'h0} - {16'h0, res, 16'h0} : cf;
          res = cfg_egress ? 32'h0 : ts;
        end
      endcase
      for (int i = 0; i < 8; i++) e[22 + i] = cf[63 - 8*i -: 8];
      for (int i = 0; i < 4; i++) e[30 + i] = res[31 - 8*i -: 8];
      seal(e, bad);
    end
    for (int i = 0; i < 64; i++) exp_q.push_back(e[i]);
    for (int i = 0; i < 64; i++) begin
      rx_valid = 1'b1;
      rx_sof = (i == 0);
      rx_eof = (i == 63);
      rx_data = f[i];
      @(posedge core_clk);
      #1;
    end
  endtask : send

  task automatic idle(input int n);
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : idle

  task automatic pop_all();
    logic [151:0] r;
    tsf_ready = 1'b1;
    while (rq.size() > 0) begin
      r = rq.pop_front();
      check(128'(tsf_valid), 128'h1);
      check(128'(tsf_id), 128'(r[151:32]));
      check(128'(tsf_ts), 128'(r[31:0]));
      @(posedge core_clk);
      #1;
    end
    tsf_ready = 1'b0;
    check(128'(tsf_valid), 128'h0);
  endtask : pop_all

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (resetn && frame_matched === 1'b1) match_count++;
    if (resetn && tsf_overflow === 1'b1) ovf_count++;
    if (resetn && tx_valid === 1'b1) begin
      if (exp_q.size() == 0) check(128'h1, 128'h0);
      else check(128'(tx_data), 128'(exp_q.pop_front()));
    end
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    cfg_enable = 1'b1;
    cfg_mode = PTPTSR_TWO_STEP;
    cfg_egress = 1'b0;
    cfg_domain = 8'h05;
    cfg_latency_ns = 32'h0000_0064;
    cfg_asym_ns = 32'hffff_fff6;
    cfg_id_offset = 16'h0022;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h00;
    tsf_ready = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    for (int m = 0; m < 3; m++) begin
      for (int g = 0; g < 2; g++) begin
        cfg_mode = ptptsr_mode_t'(m[1:0]);
        cfg_egress = g[0];
        send(4'h0, 8'h05, 1'b0);
        send(4'h1, 8'h05, 1'b0);
        idle(40);
      end
    end
    pop_all();
    cfg_mode = PTPTSR_TC_A;
    cfg_egress = 1'b0;
    send(4'h0, 8'h05, 1'b1);
    send(4'h0, 8'h06, 1'b1);
    send(4'h2, 8'h05, 1'b0);
    idle(40);
    cfg_enable = 1'b0;
    send(4'h1, 8'h05, 1'b0);
    idle(40);
    cfg_enable = 1'b1;
    cfg_mode = PTPTSR_OFF;
    send(4'h0, 8'h05, 1'b0);
    idle(40);
    cfg_mode = PTPTSR_TWO_STEP;
    cfg_egress = 1'b1;
    repeat (5) send(4'h1, 8'h05, 1'b0);
    idle(40);
    check(128'(ovf_count), 128'(ovf_exp));
    pop_all();
    resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    cfg_mode = PTPTSR_TC_B;
    send(4'h0, 8'h05, 1'b0);
    idle(40);
    check(128'(match_count), 128'(match_exp));
    give_verdict();
  end
endmodule : tb_ptp_frame_timestamp_rewriter
